// >>> logic/sccs_pkg.sv
// constants and types for the system clock source control block
package sccs_pkg;
   // register addresses (word index on the plain port)
   localparam logic [3:0] A_CSR = 4'h0;
   localparam logic [3:0] A_FTRIM = 4'h1;
   localparam logic [3:0] A_STRIM = 4'h2;
   localparam logic [3:0] A_TTRIMA = 4'h3;
   localparam logic [3:0] A_TTRIMB = 4'h4;
   localparam logic [3:0] A_FUSE = 4'h5;
   localparam logic [3:0] A_PWR = 4'h6;
   localparam logic [3:0] A_STAT = 4'h7;
   // clock setting register fields
   localparam int CSR_RDY = 7;
   localparam int CSR_TRIG = 6;
   localparam int CSR_START = 4;
   // fuse readback field
   localparam int FUSE_DIV8 = 5;
   // power control fields
   localparam int PWR_CORE = 0;
   localparam int PWR_IO = 1;
   localparam int PWR_CONV = 2;
   localparam int PWR_DOWN = 3;
   // source codes
   localparam logic [3:0] SRC_EXT = 4'h0;
   localparam logic [3:0] SRC_FAST = 4'h2;
   localparam logic [3:0] SRC_SLOW = 4'h4;
   localparam logic [1:0] IDX_SLOW = 2'h2;
   // start-up counts in source cycles
   localparam logic [15:0] CK_PD = 16'h0006;
   localparam logic [15:0] CK_RST_FAST = 16'h0014;
   localparam logic [15:0] CK_RST_OTH = 16'h0016;
   localparam logic [15:0] CK_RES_PD = 16'h0102;
   localparam logic [15:0] CK_RES_RST = 16'h0112;
   localparam logic [15:0] CK_RES_1K = 16'h0400;
   localparam int CK_XTAL_DEF = 16384;
   // reset time-out in slow oscillator cycles, rounded up
   localparam int TOUT_MS = 16;
   localparam int SLOW_HZ = 32768;
   localparam logic [15:0] TOUT_TICKS =
      16'((TOUT_MS * SLOW_HZ + 999) / 1000);
   // sync settle cycles before the fuse load
   localparam logic [1:0] LOAD_WAIT = 2'h2;
   localparam logic [7:0] PWR_RST = 8'h00;
   typedef enum logic [2:0] {
      ST_LOAD, ST_TOUT, ST_CKWAIT, ST_RUN, ST_DOWN, ST_WAKE
   } sccs_state_t;
endpackage : sccs_pkg

// >>> logic/sccs_top.sv
// system clock source selection, start-up timing and domain gating
//
// Behaviour
// - clocks of unused domains stop under sleep and power settings
// - stopping core clock halts the core completely until it resumes
// - peripheral clock domain gated separately from core clock
// - some external interrupts detected without the peripheral clock
// - flash interface clock runs whenever the core clock runs
// - converter clock keeps running while core and peripheral stop
// - system clock from external, fast, slow or resonator source
// - source fuses copied into run-time select bits at every reset
// - fuses readable but never writable by firmware
// - source switching gives no glitch or short pulse
// - power-down wake timed on selected source, execution held
// - reset start adds delay timed by slow oscillator
// - start-up length set by start-up bit and source select
// - fast trim loaded from factory value during reset
// - fast trim writable any time, each write retunes
// - both fast temperature trims loaded during reset
// - slow trim loaded from factory value during reset
// - slow oscillator still clocks watchdog and reset time-out
// - unprogrammed default is fast source, long start, divide by eight
// - codes 0000, 0010, 0100 and 1xxx; others reserved
// - select with trigger switches now, without only enables
`timescale 1ns/100ps
module sccs_top
   import sccs_pkg::*;
#(
   parameter int P_XTAL_CK = CK_XTAL_DEF // crystal start-up cycles
) (
   input wire logic SYS_CLK, // 200 MHz system clock
   input wire logic RESET_N, // async reset, active low
   input wire logic [3:0] ADDR, // register address
   input wire logic [7:0] WDATA, // write data
   input wire logic WR, // write strobe
   input wire logic RD, // read strobe
   output logic [7:0] RDATA, // read data, cycle after RD
   input wire logic EXT_CLK_IN, // external clock input pin
   input wire logic FAST_OSC_CLK, // fast internal oscillator
   input wire logic SLOW_OSC_CLK, // slow low-power oscillator
   input wire logic RESON_AMP_IN, // resonator amplifier input
   input wire logic WAKE_IRQ, // async external interrupt
   input wire logic [3:0] FUSE_SRC_SEL, // source select fuses
   input wire logic FUSE_START_SEL, // start-up time fuse
   input wire logic FUSE_DIV8, // divide by eight fuse
   input wire logic [7:0] FACT_FTRIM, // factory fast trim
   input wire logic [7:0] FACT_STRIM, // factory slow trim
   input wire logic [7:0] FACT_TTRIMA, // factory temp trim a
   input wire logic [7:0] FACT_TTRIMB, // factory temp trim b
   output logic RESON_AMP_OUT, // resonator amplifier output
   output logic [3:0] OSC_ENABLE, // ext, fast, slow, resonator
   output logic [7:0] FAST_OSC_TRIM, // fast oscillator trim
   output logic [7:0] SLOW_OSC_TRIM, // slow oscillator trim
   output logic [7:0] TEMP_TRIM_A, // fast temp trim a
   output logic [7:0] TEMP_TRIM_B, // fast temp trim b
   output logic PRESCALE_DIV8, // prescaler divide by eight
   output logic CORE_CLK, // gated core clock
   output logic PERIPH_CLK, // gated peripheral clock
   output logic FLASH_CLK, // gated flash interface clock
   output logic CONV_CLK, // gated converter clock
   output logic EXEC_HOLD // instruction execution held
);

   // map a select code to its source index
   function automatic logic [1:0] src_idx(input logic [3:0] c);
      if (c[3]) begin
         return 2'h3;
      end else if (c == SRC_FAST) begin
         return 2'h1;
      end else if (c == SRC_SLOW) begin
         return IDX_SLOW;
      end
      return 2'h0;
   endfunction : src_idx

   // reserved codes are refused
   function automatic logic code_ok(input logic [3:0] c);
      return c[3] || c == SRC_EXT || c == SRC_FAST || c == SRC_SLOW;
   endfunction : code_ok

   // start-up cycles from source, start bit and cause
   function automatic logic [15:0] ck_count(input logic [3:0] c,
      input logic ss, input logic rst);
      if (c[3] && ss && !c[0]) begin
         return CK_RES_1K;
      end else if (c[3] && c[0]) begin
         return 16'(P_XTAL_CK);
      end else if (c[3]) begin
         return rst ? CK_RES_RST : CK_RES_PD;
      end else if (!rst) begin
         return CK_PD;
      end
      return (c == SRC_FAST) ? CK_RST_FAST : CK_RST_OTH;
   endfunction : ck_count

   sccs_state_t state_reg, state_next;
   logic [3:0] src_s1, src_s2, src_d;
   logic [3:0] rise;
   logic irq_s1, irq_s2;
   logic [37:0] fz_s1, fz_s2;
   logic [1:0] load_cnt_reg;
   logic [15:0] cnt_reg;
   logic [15:0] warm_cnt_reg;
   logic [3:0] act_sel_reg, pend_sel_reg, tgt_reg;
   logic start_sel_reg, sw_reg, rdy_reg;
   logic [3:0] fuse_sel_reg;
   logic fuse_start_reg;
   logic [7:0] pwr_reg;
   logic sys_reg, sys_next, lvl_cur;
   logic gate_core_reg, gate_io_reg, gate_conv_reg;
   logic gc_eff, gi_eff, gv_eff;
   logic load_now, wr_csr, trig_ok, sw_done, act_rise;

   // pins and oscillators pass two flops; third flop only for edges
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         src_s1 <= 4'h0;
         src_s2 <= 4'h0;
         src_d <= 4'h0;
      end else begin
         src_s1 <= {RESON_AMP_IN, SLOW_OSC_CLK, FAST_OSC_CLK, EXT_CLK_IN};
         src_s2 <= src_s1;
         src_d <= src_s2;
      end
   end
   assign rise = src_s2 & ~src_d;
   assign act_rise = rise[src_idx(act_sel_reg)];
   assign lvl_cur = src_s2[src_idx(act_sel_reg)];

   // interrupt seen on the free-running clock, not the gated one
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         irq_s1 <= 1'b0;
         irq_s2 <= 1'b0;
      end else begin
         irq_s1 <= WAKE_IRQ;
         irq_s2 <= irq_s1;
      end
   end

   // fuse and factory values are static but still synchronised
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         fz_s1 <= 38'h0;
         fz_s2 <= 38'h0;
      end else begin
         fz_s1 <= {FUSE_DIV8, FUSE_START_SEL, FUSE_SRC_SEL, FACT_FTRIM,
            FACT_STRIM, FACT_TTRIMA, FACT_TTRIMB};
         fz_s2 <= fz_s1;
      end
   end

   assign load_now = state_reg == ST_LOAD && load_cnt_reg == LOAD_WAIT;
   assign wr_csr = WR && ADDR == A_CSR;
   assign trig_ok = wr_csr && WDATA[CSR_TRIG] && code_ok(WDATA[3:0]);
   assign sw_done = sw_reg && !sys_reg && !src_s2[src_idx(tgt_reg)];

   // settle counter before the fuse load
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         load_cnt_reg <= 2'h0;
      end else if (state_reg == ST_LOAD && !load_now) begin
         load_cnt_reg <= load_cnt_reg + 2'h1;
      end
   end

   // start-up sequencing
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_LOAD: begin
            if (load_now) begin
               state_next = ST_TOUT;
            end
         end
         ST_TOUT: begin
            if (rise[IDX_SLOW] && cnt_reg == TOUT_TICKS - 16'h1) begin
               state_next = ST_CKWAIT;
            end
         end
         ST_CKWAIT: begin
            if (act_rise &&
               cnt_reg == ck_count(act_sel_reg, start_sel_reg, 1'b1) - 16'h1)
            begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (pwr_reg[PWR_DOWN]) begin
               state_next = ST_DOWN;
            end
         end
         ST_DOWN: begin
            if (irq_s2) begin
               state_next = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (act_rise &&
               cnt_reg == ck_count(act_sel_reg, start_sel_reg, 1'b0) - 16'h1)
            begin
               state_next = ST_RUN;
            end
         end
         default: state_next = ST_LOAD;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_reg <= ST_LOAD;
      end else begin
         state_reg <= state_next;
      end
   end

   // one counter serves time-out, reset start and wake start
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cnt_reg <= 16'h0;
      end else if (state_next != state_reg) begin
         cnt_reg <= 16'h0;
      end else if (state_reg == ST_TOUT && rise[IDX_SLOW]) begin
         cnt_reg <= cnt_reg + 16'h1;
      end else if ((state_reg == ST_CKWAIT || state_reg == ST_WAKE) &&
         act_rise) begin
         cnt_reg <= cnt_reg + 16'h1;
      end
   end

   // execution held until start-up completes
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         EXEC_HOLD <= 1'b1;
      end else begin
         EXEC_HOLD <= state_next != ST_RUN;
      end
   end

   // select bits: fuse load, plain write, triggered switch
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         act_sel_reg <= SRC_FAST;
         pend_sel_reg <= SRC_FAST;
         tgt_reg <= SRC_FAST;
         start_sel_reg <= 1'b1;
         sw_reg <= 1'b0;
      end else if (load_now) begin
         act_sel_reg <= fz_s2[35:32];
         pend_sel_reg <= fz_s2[35:32];
         tgt_reg <= fz_s2[35:32];
         start_sel_reg <= fz_s2[36];
         sw_reg <= 1'b0;
      end else begin
         if (wr_csr) begin
            start_sel_reg <= WDATA[CSR_START];
         end
         if (wr_csr && code_ok(WDATA[3:0])) begin
            pend_sel_reg <= WDATA[3:0];
         end
         if (trig_ok) begin
            tgt_reg <= WDATA[3:0];
            sw_reg <= 1'b1;
         end else if (sw_done) begin
            act_sel_reg <= tgt_reg;
            sw_reg <= 1'b0;
         end
      end
   end

   // ready flag: pending source warmed for its wake count
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         warm_cnt_reg <= 16'h0;
         rdy_reg <= 1'b0;
      end else if (load_now || (wr_csr && code_ok(WDATA[3:0]))) begin
         warm_cnt_reg <= 16'h0;
         rdy_reg <= 1'b0;
      end else if (!rdy_reg && rise[src_idx(pend_sel_reg)]) begin
         warm_cnt_reg <= warm_cnt_reg + 16'h1;
         if (warm_cnt_reg == ck_count(pend_sel_reg, start_sel_reg, 1'b0) -
            16'h1) begin
            rdy_reg <= 1'b1;
         end
      end
   end

   // fuse snapshot readable only
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         fuse_sel_reg <= SRC_FAST;
         fuse_start_reg <= 1'b1;
         PRESCALE_DIV8 <= 1'b1;
      end else if (load_now) begin
         fuse_sel_reg <= fz_s2[35:32];
         fuse_start_reg <= fz_s2[36];
         PRESCALE_DIV8 <= fz_s2[37];
      end
   end

   // trims: factory load at reset, firmware may overwrite
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         FAST_OSC_TRIM <= 8'h00;
         SLOW_OSC_TRIM <= 8'h00;
         TEMP_TRIM_A <= 8'h00;
         TEMP_TRIM_B <= 8'h00;
      end else if (load_now) begin
         FAST_OSC_TRIM <= fz_s2[31:24];
         SLOW_OSC_TRIM <= fz_s2[23:16];
         TEMP_TRIM_A <= fz_s2[15:8];
         TEMP_TRIM_B <= fz_s2[7:0];
      end else if (WR) begin
         if (ADDR == A_FTRIM) begin
            FAST_OSC_TRIM <= WDATA;
         end
         if (ADDR == A_STRIM) begin
            SLOW_OSC_TRIM <= WDATA;
         end
         if (ADDR == A_TTRIMA) begin
            TEMP_TRIM_A <= WDATA;
         end
         if (ADDR == A_TTRIMB) begin
            TEMP_TRIM_B <= WDATA;
         end
      end
   end

   // power control; the wake interrupt ends idle and power-down
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pwr_reg <= PWR_RST;
      end else if (WR && ADDR == A_PWR) begin
         pwr_reg <= {4'h0, WDATA[3:0]};
      end else if (irq_s2) begin
         pwr_reg[PWR_DOWN] <= 1'b0;
         pwr_reg[PWR_CORE] <= 1'b0;
      end
   end

   // oscillator enables; slow one always on for watchdog
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         OSC_ENABLE <= 4'h0;
         RESON_AMP_OUT <= 1'b0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            OSC_ENABLE[i] <= (i == int'(IDX_SLOW)) ||
               (state_reg != ST_DOWN && state_reg != ST_LOAD &&
               (i == int'(src_idx(act_sel_reg)) ||
               i == int'(src_idx(pend_sel_reg)) ||
               (sw_reg && i == int'(src_idx(tgt_reg)))));
         end
         RESON_AMP_OUT <= OSC_ENABLE[3] && !src_s2[3];
      end
   end

   // system level follows source; in a switch it parks low first
   always_comb begin
      if (state_reg == ST_LOAD) begin
         sys_next = 1'b0;
      end else if (sw_reg) begin
         sys_next = sys_reg && lvl_cur;
      end else begin
         sys_next = lvl_cur;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sys_reg <= 1'b0;
      end else begin
         sys_reg <= sys_next;
      end
   end

   // gate wishes apply only while the level is low
   assign gc_eff = sys_reg ? gate_core_reg :
      (state_reg == ST_RUN && !pwr_reg[PWR_CORE]);
   assign gi_eff = sys_reg ? gate_io_reg :
      (state_reg == ST_RUN && !pwr_reg[PWR_IO]);
   assign gv_eff = sys_reg ? gate_conv_reg :
      (state_reg == ST_RUN && !pwr_reg[PWR_CONV]);

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         gate_core_reg <= 1'b0;
         gate_io_reg <= 1'b0;
         gate_conv_reg <= 1'b0;
      end else begin
         gate_core_reg <= gc_eff;
         gate_io_reg <= gi_eff;
         gate_conv_reg <= gv_eff;
      end
   end

   // gated domain clocks, all from flops
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         CORE_CLK <= 1'b0;
         FLASH_CLK <= 1'b0;
         PERIPH_CLK <= 1'b0;
         CONV_CLK <= 1'b0;
      end else begin
         CORE_CLK <= sys_next && gc_eff;
         FLASH_CLK <= sys_next && gc_eff;
         PERIPH_CLK <= sys_next && gi_eff;
         CONV_CLK <= sys_next && gv_eff;
      end
   end

   // read data stands for one cycle only
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         RDATA <= 8'h00;
      end else if (!RD) begin
         RDATA <= 8'h00;
      end else begin
         case (ADDR)
            A_CSR: RDATA <= {rdy_reg, 2'b00, start_sel_reg, pend_sel_reg};
            A_FTRIM: RDATA <= FAST_OSC_TRIM;
            A_STRIM: RDATA <= SLOW_OSC_TRIM;
            A_TTRIMA: RDATA <= TEMP_TRIM_A;
            A_TTRIMB: RDATA <= TEMP_TRIM_B;
            A_FUSE: RDATA <= {2'b00, PRESCALE_DIV8, fuse_start_reg,
               fuse_sel_reg};
            A_PWR: RDATA <= pwr_reg;
            A_STAT: RDATA <= {act_sel_reg, sw_reg, gate_conv_reg,
               gate_io_reg, gate_core_reg};
            default: RDATA <= 8'h00;
         endcase
      end
   end

   // checks beside the logic
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);

   gate_low_change_a: assert property (
      $changed(gate_core_reg) |-> !$past(sys_reg))
      else $error("core gate moved while clock high");
   core_stop_a: assert property (
      $rose(CORE_CLK) |-> $past(state_reg == ST_RUN) &&
      !$past(pwr_reg[PWR_CORE]))
      else $error("core clock started while stopped");
   flash_core_a: assert property (FLASH_CLK == CORE_CLK)
      else $error("flash clock differs from core clock");
   conv_run_a: assert property (
      $rose(CONV_CLK) |-> !$past(pwr_reg[PWR_CONV]))
      else $error("converter clock started while stopped");
   fuse_load_a: assert property (
      load_now |=> act_sel_reg == $past(fz_s2[35:32]) &&
      start_sel_reg == $past(fz_s2[36]))
      else $error("select fuses not loaded");
   trim_load_a: assert property (
      load_now |=> FAST_OSC_TRIM == $past(fz_s2[31:24]) &&
      SLOW_OSC_TRIM == $past(fz_s2[23:16]))
      else $error("factory trim not loaded");
   wake_hold_a: assert property (
      state_reg == ST_WAKE |-> EXEC_HOLD)
      else $error("execution not held during wake");
   switch_clean_a: assert property (
      $changed(act_sel_reg) && !$past(load_now) |->
      !sys_reg && !$past(sys_reg))
      else $error("source changed while clock high");
   no_trig_a: assert property (
      wr_csr && !WDATA[CSR_TRIG] && !sw_reg && !load_now |=>
      $stable(act_sel_reg))
      else $error("select without trigger switched clock");
   tout_len_a: assert property (
      state_reg == ST_TOUT && state_next == ST_CKWAIT |->
      cnt_reg == TOUT_TICKS - 16'h1)
      else $error("reset time-out length wrong");

   switch_c: cover property (sw_reg ##1 !sw_reg);
   wake_c: cover property (state_reg == ST_DOWN ##1 state_reg == ST_WAKE);
   ready_c: cover property ($rose(rdy_reg));
   idle_c: cover property (gate_conv_reg && !gate_core_reg);

endmodule : sccs_top

// >>> tb/sccs_osc_model.sv
// oscillator sources standing at the far side of the clock control block
`timescale 1ns/100ps
module sccs_osc_model (
   input wire logic [3:0] OSC_ENABLE, // ext, fast, slow, resonator
   output logic EXT_CLK_IN, // external clock pin
   output logic FAST_OSC_CLK, // fast oscillator
   output logic SLOW_OSC_CLK, // slow oscillator, sped up to save run time
   output logic RESON_AMP_IN // resonator at the amplifier input
);
   // start all sources low so the synchronisers never see an unknown
   initial begin
      EXT_CLK_IN = 1'b0;
      FAST_OSC_CLK = 1'b0;
      SLOW_OSC_CLK = 1'b0;
      RESON_AMP_IN = 1'b0;
   end
   // external source runs free at one fixed period, no step at all
   always #30 EXT_CLK_IN = ~EXT_CLK_IN;
   // internal sources stand still low while their enable is off
   always #20 FAST_OSC_CLK = OSC_ENABLE[1] ? ~FAST_OSC_CLK : 1'b0;
   always #40 SLOW_OSC_CLK = OSC_ENABLE[2] ? ~SLOW_OSC_CLK : 1'b0;
   always #25 RESON_AMP_IN = OSC_ENABLE[3] ? ~RESON_AMP_IN : 1'b0;
endmodule : sccs_osc_model

// >>> tb/sccs_top_test.sv
// self-checking bench for the system clock source control block
`timescale 1ns/100ps
module sccs_top_test;
   import sccs_pkg::*;
   logic SYS_CLK, RESET_N, WR, RD, WAKE_IRQ, FUSE_START_SEL, FUSE_DIV8;
   logic [3:0] ADDR, FUSE_SRC_SEL, OSC_ENABLE, m;
   logic [7:0] WDATA, RDATA, FACT_FTRIM, FACT_STRIM, FACT_TTRIMA, FACT_TTRIMB;
   logic [7:0] FAST_OSC_TRIM, SLOW_OSC_TRIM, TEMP_TRIM_A, TEMP_TRIM_B, v;
   logic EXT_CLK_IN, FAST_OSC_CLK, SLOW_OSC_CLK, RESON_AMP_IN, RESON_AMP_OUT;
   logic PRESCALE_DIV8, CORE_CLK, PERIPH_CLK, FLASH_CLK, CONV_CLK, EXEC_HOLD;
   int miscompares, checked, cyc, n;

   // short crystal count keeps the run brief
   sccs_top #(.P_XTAL_CK(16)) dut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
      .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .EXT_CLK_IN(EXT_CLK_IN), .FAST_OSC_CLK(FAST_OSC_CLK),
      .SLOW_OSC_CLK(SLOW_OSC_CLK), .RESON_AMP_IN(RESON_AMP_IN),
      .WAKE_IRQ(WAKE_IRQ), .FUSE_SRC_SEL(FUSE_SRC_SEL),
      .FUSE_START_SEL(FUSE_START_SEL),
      .FUSE_DIV8(FUSE_DIV8), .FACT_FTRIM(FACT_FTRIM),
      .FACT_STRIM(FACT_STRIM), .FACT_TTRIMA(FACT_TTRIMA),
      .FACT_TTRIMB(FACT_TTRIMB), .RESON_AMP_OUT(RESON_AMP_OUT),
      .OSC_ENABLE(OSC_ENABLE), .FAST_OSC_TRIM(FAST_OSC_TRIM),
      .SLOW_OSC_TRIM(SLOW_OSC_TRIM), .TEMP_TRIM_A(TEMP_TRIM_A),
      .TEMP_TRIM_B(TEMP_TRIM_B), .PRESCALE_DIV8(PRESCALE_DIV8),
      .CORE_CLK(CORE_CLK), .PERIPH_CLK(PERIPH_CLK), .FLASH_CLK(FLASH_CLK),
      .CONV_CLK(CONV_CLK), .EXEC_HOLD(EXEC_HOLD));
   sccs_osc_model osc (.OSC_ENABLE(OSC_ENABLE), .EXT_CLK_IN(EXT_CLK_IN),
      .FAST_OSC_CLK(FAST_OSC_CLK), .SLOW_OSC_CLK(SLOW_OSC_CLK),
      .RESON_AMP_IN(RESON_AMP_IN));

   task automatic tally_and_finish;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge SYS_CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge SYS_CLK);
      WR <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge SYS_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge SYS_CLK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask : rd

   // bounded wait for the execution hold to reach a level
   task automatic wait_hold(input logic lvl, output int k);
      k = 0;
      while (EXEC_HOLD !== lvl && k < 20000) begin
         @(posedge SYS_CLK);
         #1 k++;
      end
      chk({7'h00, EXEC_HOLD}, {7'h00, lvl});
   endtask : wait_hold

   // which gated clocks pulse high once the gates have settled
   task automatic clk_mask(output logic [3:0] g);
      repeat (16) @(posedge SYS_CLK);
      g = 4'h0;
      repeat (64) begin
         @(posedge SYS_CLK);
         #1 g = g | {CONV_CLK, PERIPH_CLK, FLASH_CLK, CORE_CLK};
      end
   endtask : clk_mask

   task automatic do_reset(input logic [3:0] ck, input logic ss,
                           input logic dv, input logic [7:0] t);
      @(posedge SYS_CLK);
      RESET_N <= 1'b0;
      FUSE_SRC_SEL <= ck;
      FUSE_START_SEL <= ss;
      FUSE_DIV8 <= dv;
      FACT_FTRIM <= t;
      FACT_STRIM <= ~t;
      FACT_TTRIMA <= 8'(t + 8'h01);
      FACT_TTRIMB <= 8'(t - 8'h01);
      repeat (16) @(posedge SYS_CLK);
      RESET_N <= 1'b1;
      wait_hold(1'b0, n);
      chk({7'h00, n > 8000}, 8'h01); // slow time-out first
      chk(FAST_OSC_TRIM, t); // fast trim loaded
      chk(SLOW_OSC_TRIM, ~t); // slow trim loaded
      chk(TEMP_TRIM_A, 8'(t + 8'h01)); // temp trim a loaded
      chk(TEMP_TRIM_B, 8'(t - 8'h01)); // temp trim b loaded
      chk({7'h00, PRESCALE_DIV8}, {7'h00, dv}); // divider fuse
      rd(A_FUSE, v);
      chk(v, {2'b00, dv, ss, ck}); // fuse readback
      rd(A_CSR, v);
      chk(v & 8'h1F, {3'b000, ss, ck}); // select from fuses
      rd(A_STAT, v);
      chk({4'h0, v[7:4]}, {4'h0, ck}); // active source
   endtask : do_reset

   task automatic t_regs;
      wr(A_FTRIM, 8'h77);
      rd(A_FTRIM, v);
      chk(v, 8'h77); // trim writable
      chk(FAST_OSC_TRIM, 8'h77); // oscillator retuned
      wr(A_FUSE, 8'h00);
      rd(A_FUSE, v);
      chk(v, 8'h32); // fuses ignore writes
      rd(4'hC, v);
      chk(v, 8'h00); // unmapped place reads zero
   endtask : t_regs

   task automatic t_switch;
      wr(A_CSR, 8'h10);
      repeat (4) @(posedge SYS_CLK);
      #1 chk({7'h00, OSC_ENABLE[0]}, 8'h01); // enabled only
      rd(A_STAT, v);
      chk({4'h0, v[7:4]}, {4'h0, SRC_FAST}); // still fast
      wr(A_CSR, 8'h13);
      rd(A_CSR, v);
      chk(v & 8'h0F, {4'h0, SRC_EXT}); // reserved code refused
      wr(A_CSR, 8'h50);
      n = 0;
      v = 8'hFF;
      while (v[7:4] !== SRC_EXT && n < 200) begin
         rd(A_STAT, v);
         n++;
      end
      chk({4'h0, v[7:4]}, {4'h0, SRC_EXT}); // trigger switches
      clk_mask(m);
      chk({4'h0, m}, 8'h0F); // new source reaches domains
      // resonator picked without trigger: amplifier runs, clock stays
      wr(A_CSR, 8'h08);
      repeat (8) @(posedge SYS_CLK);
      #1 chk({7'h00, OSC_ENABLE[3]}, 8'h01); // resonator enabled
      v = 8'h00;
      repeat (32) begin
         @(posedge SYS_CLK);
         #1 v = v | {6'h00, RESON_AMP_OUT, ~RESON_AMP_OUT};
      end
      chk(v, 8'h03); // amplifier output toggles
      rd(A_STAT, v);
      chk({4'h0, v[7:4]}, {4'h0, SRC_EXT}); // clock kept
   endtask : t_switch

   task automatic t_power;
      wr(A_PWR, 8'h01);
      clk_mask(m);
      chk({4'h0, m}, 8'h0C); // core and flash stop together
      wr(A_PWR, 8'h06);
      clk_mask(m);
      chk({4'h0, m}, 8'h03); // peripheral gated apart
      wr(A_PWR, 8'h03);
      clk_mask(m);
      chk({4'h0, m}, 8'h08); // converter keeps running
      wr(A_PWR, 8'h00);
   endtask : t_power

   task automatic t_wake;
      wr(A_PWR, 8'h08);
      wait_hold(1'b1, n);
      clk_mask(m);
      chk({7'h00, m[0]}, 8'h00); // core halted in power-down
      @(posedge SYS_CLK);
      WAKE_IRQ <= 1'b1;
      wait_hold(1'b0, n);
      chk({7'h00, n > 50}, 8'h01); // wake timed on source
      @(posedge SYS_CLK);
      WAKE_IRQ <= 1'b0;
      rd(A_PWR, v);
      chk(v & 8'h0F, 8'h00); // async wake clears power-down
   endtask : t_wake

   // clock source for the block
   initial begin
      SYS_CLK = 1'b0;
      forever #2.5 SYS_CLK = ~SYS_CLK;
   end

   // hang guard, well above two resets and the scenarios
   always @(posedge SYS_CLK) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   initial begin
      {RESET_N, WR, RD, WAKE_IRQ, ADDR, WDATA} = '0;
      {FUSE_SRC_SEL, FUSE_START_SEL, FUSE_DIV8} = {SRC_FAST, 2'b11};
      {FACT_FTRIM, FACT_STRIM, FACT_TTRIMA, FACT_TTRIMB} = '0;
      do_reset(SRC_FAST, 1'b1, 1'b1, 8'h5A); // shipped defaults
      t_regs();
      t_switch();
      t_power();
      t_wake();
      do_reset(SRC_SLOW, 1'b0, 1'b0, 8'h3E); // fuses reload
      tally_and_finish();
   end
endmodule : sccs_top_test
